// *** core/cpu_power_mode_control.sv ***
// Power-mode sequencer for the CPU core: idle, stop and reset exits.
// Operation
// - Idle write halts CPU after instruction; peripherals run.
// - Idle gates CPU clock only; peripheral clock on.
// - Idle preserves registers and memory contents.
// - Enabled interrupt or reset ends idle.
// - Interrupt serviced, then resume after idle instruction.
// - Reset out of idle restarts at zero.
// - Watchdog reset ends idle.
// - Stop write enters stop after instruction.
// - Stop halts CPU and oscillators; detector stays.
// - Only reset ends stop; restart at zero.
// - Missing clock detector reset ends stop after timeout.
// - Stop bit1, idle bit0, resets zero.
// - Mode select bits read back zero.
`timescale 1ns/10ps
module cpu_power_mode_control
    import power_mode_pkg::*;
#(
    parameter int DETECTOR_CYCLES = DETECTOR_TIMEOUT_CYCLES,
    parameter int SEQ_CYCLES = RESET_SEQ_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire sfr_req_type sfr_req,
    input wire logic ext_reset_pin_n,
    input wire logic irq_pending,
    input wire logic watchdog_reset,
    input wire logic detector_enable,
    output logic [7:0] sfr_rdata,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_en,
    output logic cpu_reset_hold,
    output logic [19:0] fetch_addr,
    output logic fetch_load,
    output logic in_idle,
    output logic in_stop,
    output logic detector_reset
);
    logic rst_sync_n;
    logic [2:0] pin_sync_r;
    logic ext_reset_r;
    power_mode_type mode_r;
    power_mode_type mode_nxt;
    logic idle_req_r;
    logic stop_req_r;
    logic [$clog2(DETECTOR_CYCLES + 1) - 1:0] detector_cnt_r;
    logic [$clog2(SEQ_CYCLES + 1) - 1:0] seq_cnt_r;
    wake_src_type wake_src;
    logic any_reset;
    logic power_control_wr;

    function automatic logic hits(input logic [7:0] addr);
        hits = addr == POWER_CONTROL_ADDR;
    endfunction : hits

    // The oscillator and the peripheral clock run in every mode but stop.
    function automatic logic osc_running(input power_mode_type mode);
        osc_running = mode != mode_stop;
    endfunction : osc_running

    reset_sync u_reset_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    // The reset pin passes three stages; a change counts when the last two agree.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_sync_r <= 3'h7;
            ext_reset_r <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], ext_reset_pin_n};
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                ext_reset_r <= ~pin_sync_r[2];
            end
        end
    end

    // Wake and reset sources are gathered so each mode decision reads one bundle.
    always_comb begin
        wake_src.irq_pending = irq_pending;
        wake_src.ext_reset = ext_reset_r;
        wake_src.watchdog_reset = watchdog_reset;
        wake_src.detector_enable = detector_enable;
    end

    assign power_control_wr = sfr_req.wr && hits(sfr_req.addr);
    // Any reset source wins over every mode, including a pending mode request.
    assign any_reset = wake_src.ext_reset || wake_src.watchdog_reset
        || detector_reset;

    // A request is latched on the write and acted on when the instruction completes.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            idle_req_r <= 1'b0;
            stop_req_r <= 1'b0;
        end else if (any_reset || mode_r != mode_run) begin
            idle_req_r <= 1'b0;
            stop_req_r <= 1'b0;
        end else if (power_control_wr) begin
            idle_req_r <= sfr_req.wdata[IDLE_SELECT_BIT];
            stop_req_r <= sfr_req.wdata[STOP_SELECT_BIT];
        end else if (sfr_req.instr_done) begin
            idle_req_r <= 1'b0;
            stop_req_r <= 1'b0;
        end
    end

    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            // Stop outranks idle when both bits are written together.
            mode_run: begin
                if (any_reset) begin
                    mode_nxt = mode_reset_seq;
                end else if (sfr_req.instr_done && stop_req_r) begin
                    mode_nxt = mode_stop;
                end else if (sfr_req.instr_done && idle_req_r) begin
                    mode_nxt = mode_idle;
                end
            end
            mode_idle: begin
                if (any_reset) begin
                    mode_nxt = mode_reset_seq;
                end else if (wake_src.irq_pending) begin
                    mode_nxt = mode_run;
                end
            end
            mode_stop: begin
                if (any_reset) begin
                    mode_nxt = mode_reset_seq;
                end
            end
            mode_reset_seq: begin
                if (!any_reset && seq_cnt_r == '0) begin
                    mode_nxt = mode_run;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_r <= mode_reset_seq;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            seq_cnt_r <= ($clog2(SEQ_CYCLES + 1))'(SEQ_CYCLES);
        end else if (any_reset || (mode_nxt == mode_reset_seq && mode_r != mode_reset_seq)) begin
            seq_cnt_r <= ($clog2(SEQ_CYCLES + 1))'(SEQ_CYCLES);
        end else if (seq_cnt_r != '0) begin
            seq_cnt_r <= seq_cnt_r - 1'b1;
        end
    end

    // The detector counts while the oscillator is off and fires after its timeout.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            detector_cnt_r <= '0;
            detector_reset <= 1'b0;
        end else if (mode_r == mode_stop && wake_src.detector_enable) begin
            if (detector_cnt_r == ($clog2(DETECTOR_CYCLES + 1))'(DETECTOR_CYCLES - 1)) begin
                detector_reset <= 1'b1;
            end else begin
                detector_cnt_r <= detector_cnt_r + 1'b1;
            end
        end else begin
            detector_cnt_r <= '0;
            detector_reset <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b1;
            osc_en <= 1'b1;
            cpu_reset_hold <= 1'b1;
        end else begin
            cpu_clk_en <= mode_nxt == mode_run;
            periph_clk_en <= osc_running(mode_nxt);
            osc_en <= osc_running(mode_nxt);
            cpu_reset_hold <= mode_nxt == mode_reset_seq;
        end
    end

    // The mode flags follow the next mode so they change on the same edge as the enables.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            in_idle <= 1'b0;
            in_stop <= 1'b0;
        end else begin
            in_idle <= mode_nxt == mode_idle;
            in_stop <= mode_nxt == mode_stop;
        end
    end

    // Fetch restarts at the reset vector as the reset sequence ends.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fetch_addr <= RESET_VECTOR;
            fetch_load <= 1'b0;
        end else begin
            fetch_addr <= RESET_VECTOR;
            fetch_load <= mode_r == mode_reset_seq && mode_nxt == mode_run;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sfr_rdata <= POWER_CONTROL_RESET;
        end else begin
            sfr_rdata <= POWER_CONTROL_RESET;
        end
    end
endmodule : cpu_power_mode_control

// *** core/power_mode_pkg.sv ***
// Package with the power-control register map, fields and sequencer types.
package power_mode_pkg;

    localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
    localparam int IDLE_SELECT_BIT = 0;
    localparam int STOP_SELECT_BIT = 1;
    localparam logic [19:0] RESET_VECTOR = 20'h00000;
    localparam int DETECTOR_TIMEOUT_US = 100;
    localparam int CLOCK_MHZ = 25;
    localparam int DETECTOR_TIMEOUT_CYCLES = DETECTOR_TIMEOUT_US * CLOCK_MHZ;
    localparam int RESET_SEQ_CYCLES = 4;

    typedef enum {
        mode_run,
        mode_idle,
        mode_stop,
        mode_reset_seq
    } power_mode_type;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic instr_done;
    } sfr_req_type;

    typedef struct packed {
        logic irq_pending;
        logic ext_reset;
        logic watchdog_reset;
        logic detector_enable;
    } wake_src_type;

endpackage : power_mode_pkg

// *** core/reset_sync.sv ***
// Two-stage release synchroniser for the asynchronous active-low reset.
`timescale 1ns/10ps
module reset_sync (
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic rst_sync_n
);
    logic stage_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            stage_r <= 1'b1;
            rst_sync_n <= stage_r;
        end
    end
endmodule : reset_sync

// *** sim/cpu_model.sv ***
// Behavioural CPU core that completes each register write instruction.
`timescale 1ns/10ps
module cpu_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr,
    output logic instr_done
);
    // Each write finishes one cycle later; nothing else completes meanwhile.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= wr;
        end
    end
endmodule : cpu_model

// *** sim/power_mode_chk.sv ***
// Checker for the power-mode sequencer ports.
`timescale 1ns/10ps
module power_mode_chk
    import power_mode_pkg::*;
#(
    parameter int DETECTOR_CYCLES = 20,
    parameter int SEQ_CYCLES = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire sfr_req_type sfr_req,
    input wire logic ext_reset_pin_n,
    input wire logic irq_pending,
    input wire logic watchdog_reset,
    input wire logic detector_enable,
    input wire logic [7:0] sfr_rdata,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic osc_en,
    input wire logic cpu_reset_hold,
    input wire logic [19:0] fetch_addr,
    input wire logic fetch_load,
    input wire logic in_idle,
    input wire logic in_stop,
    input wire logic detector_reset
);
    localparam int DETECTOR_LIM = DETECTOR_CYCLES + SEQ_CYCLES + 8;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    rdata_zero_a: assert property (sfr_rdata == 8'h00)
        else $error("mode bits read nonzero");
    idle_clocks_a: assert property ($rose(in_idle) |->
        !cpu_clk_en && periph_clk_en && osc_en) else $error("idle clocks wrong");
    stop_clocks_a: assert property (in_stop |->
        !osc_en && !periph_clk_en && !cpu_clk_en && !in_idle) else $error("stop clocks wrong");
    idle_wake_a: assert property (in_idle && irq_pending |->
        ##[1:2] (!in_idle && cpu_clk_en)) else $error("idle not ended by interrupt");
    stop_hold_a: assert property (in_stop && irq_pending && !detector_enable &&
        !watchdog_reset && ext_reset_pin_n && $past(ext_reset_pin_n, 4) |=> in_stop)
        else $error("stop left");
    fetch_zero_a: assert property (fetch_load |-> fetch_addr == 20'h00000)
        else $error("restart not at zero");
    load_pulse_a: assert property (fetch_load |=> !fetch_load)
        else $error("restart strobe longer than one cycle");
    detector_exit_a: assert property (in_stop && detector_enable |->
        ##[0:DETECTOR_LIM] detector_reset) else $error("detector reset missing");
    wdog_exit_a: assert property (in_idle && watchdog_reset |-> ##[1:4] cpu_reset_hold)
        else $error("watchdog did not end idle");
    idle_cov: cover property ($rose(in_idle));
    stop_cov: cover property ($rose(in_stop));
    detector_cov: cover property ($rose(detector_reset));
endmodule : power_mode_chk

bind cpu_power_mode_control power_mode_chk #(.DETECTOR_CYCLES(DETECTOR_CYCLES),
    .SEQ_CYCLES(SEQ_CYCLES)) power_mode_chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .sfr_req(sfr_req), .ext_reset_pin_n(ext_reset_pin_n), .irq_pending(irq_pending),
    .watchdog_reset(watchdog_reset), .detector_enable(detector_enable),
    .sfr_rdata(sfr_rdata), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .osc_en(osc_en), .cpu_reset_hold(cpu_reset_hold), .fetch_addr(fetch_addr),
    .fetch_load(fetch_load), .in_idle(in_idle), .in_stop(in_stop),
    .detector_reset(detector_reset));

// *** sim/testbench.sv ***
// Self-checking bench for the power-mode sequencer.
`timescale 1ns/10ps
module testbench;
    import power_mode_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, done, ext_reset_pin_n = 1'b1;
    logic irq_pending = 1'b0, watchdog_reset = 1'b0, detector_enable = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, sfr_rdata;
    localparam int DET_SIM_CYCLES = 20;
    logic cpu_clk_en, periph_clk_en, osc_en, cpu_reset_hold, fetch_load, in_idle, in_stop;
    logic detector_reset;
    logic [19:0] fetch_addr;
    sfr_req_type req;
    int errors = 0, checks = 0, cycles = 0;
    assign req = '{wr: wr, addr: addr, wdata: wdata, rd: 1'b0, instr_done: done};
    always #20 ref_clk = ~ref_clk;
    cpu_model cpu_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .wr(wr), .instr_done(done));
    cpu_power_mode_control #(.DETECTOR_CYCLES(DET_SIM_CYCLES)) cpu_power_mode_control_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(req), .ext_reset_pin_n(ext_reset_pin_n),
        .irq_pending(irq_pending), .watchdog_reset(watchdog_reset),
        .detector_enable(detector_enable), .sfr_rdata(sfr_rdata), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .osc_en(osc_en), .cpu_reset_hold(cpu_reset_hold),
        .fetch_addr(fetch_addr), .fetch_load(fetch_load), .in_idle(in_idle),
        .in_stop(in_stop), .detector_reset(detector_reset));
    task test_done;
        if (errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    task chk(input logic [19:0] got, input logic [19:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        step(1);
        wr = 1'b0;
        step(1);
    endtask : wr_reg
    task wait_load;
        int i;
        i = 0;
        while (fetch_load !== 1'b1 && i < 80) begin
            step(1);
            i++;
        end
        chk(20'(fetch_load), 20'h1);
        chk(fetch_addr, RESET_VECTOR);
        step(3);
    endtask : wait_load
    task t_idle;
        wr_reg(8'h88, 8'h01);
        wr_reg(POWER_CONTROL_ADDR, 8'h00);
        chk(20'({in_idle, in_stop}), 20'h0);
        wr_reg(POWER_CONTROL_ADDR, 8'h01);
        chk(20'({in_idle, cpu_clk_en, periph_clk_en, osc_en}), 20'hB);
        chk(20'({cpu_reset_hold, fetch_load}), 20'h0);
        chk(20'(sfr_rdata), 20'h0);
        irq_pending = 1'b1;
        step(1);
        chk(20'({in_idle, cpu_clk_en}), 20'h1);
        chk(20'({cpu_reset_hold, fetch_load}), 20'h0);
        irq_pending = 1'b0;
        wr_reg(POWER_CONTROL_ADDR, 8'h01);
        watchdog_reset = 1'b1;
        step(1);
        watchdog_reset = 1'b0;
        wait_load();
    endtask : t_idle
    task t_stop;
        // Software is taken to have shut every analog peripheral down before each stop request.
        wr_reg(POWER_CONTROL_ADDR, 8'h03);
        chk(20'({in_stop, in_idle, osc_en, periph_clk_en, cpu_clk_en}), 20'h10);
        irq_pending = 1'b1;
        step(6);
        chk(20'(in_stop), 20'h1);
        irq_pending = 1'b0;
        detector_enable = 1'b1;
        step(DET_SIM_CYCLES - 1);
        chk(20'({in_stop, detector_reset}), 20'h2);
        step(1);
        chk(20'(detector_reset), 20'h1);
        wait_load();
        detector_enable = 1'b0;
        wr_reg(POWER_CONTROL_ADDR, 8'h02);
        chk(20'({in_stop, osc_en}), 20'h2);
        ext_reset_pin_n = 1'b0;
        step(5);
        ext_reset_pin_n = 1'b1;
        wait_load();
    endtask : t_stop
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        step(5);
        rst_n = 1'b1;
        wait_load();
        t_idle();
        t_stop();
        test_done();
    end
endmodule : testbench
